//--- verilog/ccf_pkg.sv
// shared constants, types and crc for the chained command frame link
// assumes one 100 MHz system clock on both ends
package ccf_pkg;
    localparam int          CCF_FRAME_BITS  = 32;
    localparam int          CCF_HEAD_BITS   = 20;
    localparam logic [4:0]  CCF_BCAST_ADDR  = 5'h1f;
    // device register addresses
    localparam logic [5:0]  CCF_REG_DEVID   = 6'h0a;
    localparam logic [5:0]  CCF_REG_WDT     = 6'h21;
    localparam logic [5:0]  CCF_REG_WDKEY   = 6'h22;
    localparam logic [5:0]  CCF_REG_ADC     = 6'h3d;
    localparam logic [5:0]  CCF_REG_PAGE    = 6'h3e;
    localparam logic [5:0]  CCF_REG_RDPTR   = 6'h3f;
    // reset values
    localparam logic [7:0]  CCF_RST_RDPTR   = 8'hff;
    localparam logic [7:0]  CCF_RST_WDT     = 8'h0c;
    localparam logic [7:0]  CCF_RST_ZERO    = 8'h00;
    localparam logic [4:0]  CCF_RST_ID      = 5'h00;
    // field values
    localparam logic [7:0]  CCF_PAGE0       = 8'h00;
    localparam logic [7:0]  CCF_PAGE1       = 8'h01;
    localparam logic [7:0]  CCF_WD_KEY      = 8'h5a;
    localparam int          CCF_ADC_START   = 0;
    localparam int          CCF_ADC_SECOND  = 1;
    localparam int          CCF_ADC_EXIT    = 2;
    localparam int          CCF_ID_LSB      = 2;
    localparam int          CCF_LOCK_BIT    = 1;
    localparam int          CCF_INCR_BIT    = 0;
    localparam logic [4:0]  CCF_N_PRIMARY   = 5'd18;
    localparam logic [4:0]  CCF_N_SECOND    = 5'd10;
    // crc polynomial default is arbitrary
    localparam logic [11:0] CCF_CRC_POLY    = 12'h80f;
    // host register offsets
    localparam logic [3:0]  CCF_HOST_CMD    = 4'h0;
    localparam logic [3:0]  CCF_HOST_RESP   = 4'h4;
    localparam logic [3:0]  CCF_HOST_STAT   = 4'h8;
    localparam int          CCF_SCLK_HALF   = 4;

    typedef enum logic [1:0] {CCF_MODE_CMD, CCF_MODE_PRI, CCF_MODE_SEC} ccf_mode_t;
    typedef enum logic [1:0] {CCF_WD_IDLE, CCF_WD_ARMED, CCF_WD_KEYED} ccf_wdseq_t;

    // msb first, zero seed, so an all-zero head gives an all-zero crc
    function automatic logic [11:0] ccf_crc12(input logic [19:0] d, input logic [11:0] poly);
        logic [11:0] c;
        logic        fb;
        c = '0;
        for (int i = 19; i >= 0; i--) begin
            fb = c[11] ^ d[i];
            c  = {c[10:0], 1'b0};
            if (fb) begin
                c = c ^ poly;
            end
        end
        return c;
    endfunction : ccf_crc12
endpackage : ccf_pkg

//--- verilog/ccf_link_if.sv
// serial link between the host controller and the chain's master device
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface ccf_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    modport host (output sclk, output cs_n, output mosi, input miso);
    modport dev  (input sclk, input cs_n, input mosi, output miso);
endinterface : ccf_link_if

//--- verilog/ccf_device_end.sv
// device end: a chain of monitor devices seen through the master's port
// assumes link pins synchronous to sys_clk, sclk idle low, msb first
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: frame is 32 clocks: addr,rw,reg,data,crc
// RQ2: all-ones address write reaches every device
// RQ3: page register 0x3e selects page zero/one
// RQ4: id control holds id, lock, increment
// RQ5: every device id is zero after reset
// RQ6: increment gives each slave id plus one
// RQ7: host sets pointer at 0x3f, flag zero
// RQ8: null frame per device returns id and register
// RQ9: adc control bit zero starts conversions
// RQ10: started conversions enter 32-bit readback mode
// RQ11: host waits for conversions before reading
// RQ12: 18 primary results per device, one frame each
// RQ13: host sends null frames except the last
// RQ14: 0x02 to adc control selects 10 secondaries
// RQ15: 0x04 to adc control returns command mode
// RQ16: watchdog off only by zero, key, zero
// RQ17: readback runs master first, then slaves
// RQ18: pointer writable on any page, resets 0xff
// RQ19: 12-bit crc covers the 20 head bits
module ccf_device_end
    import ccf_pkg::*;
#(
    parameter int          CHAIN_LEN = 3,
    parameter logic [11:0] CRC_POLY  = CCF_CRC_POLY,
    parameter bit          CRC_CHECK = 1'b1
) (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    // link
    ccf_link_if.dev         lnk,
    // user side
    output ccf_mode_t       mode_o,
    output logic            conv_start_o,
    output logic            crc_err_o,
    output logic            wd_enabled_o,
    output logic [4:0]      master_id_o
);
    localparam int IW = $clog2(CHAIN_LEN + 1);
    localparam logic [IW-1:0] LAST_DEV = IW'(CHAIN_LEN);
    logic              sclk_prev_q, sclk_prev_d, cs_prev_q, cs_prev_d;
    logic [31:0]       sh_in_q, sh_in_d, sh_out_q, sh_out_d;
    logic [5:0]        bit_cnt_q, bit_cnt_d;
    logic [4:0]        id_q    [CHAIN_LEN], id_d    [CHAIN_LEN];
    logic              lock_q  [CHAIN_LEN], lock_d  [CHAIN_LEN];
    logic              incr_q  [CHAIN_LEN], incr_d  [CHAIN_LEN];
    logic [7:0]        page_q  [CHAIN_LEN], page_d  [CHAIN_LEN];
    logic [7:0]        rdptr_q [CHAIN_LEN], rdptr_d [CHAIN_LEN];
    logic [7:0]        wdt_q   [CHAIN_LEN], wdt_d   [CHAIN_LEN];
    logic [7:0]        wdkey_q [CHAIN_LEN], wdkey_d [CHAIN_LEN];
    logic [7:0]        adc_q   [CHAIN_LEN], adc_d   [CHAIN_LEN];
    ccf_wdseq_t        wdseq_q [CHAIN_LEN], wdseq_d [CHAIN_LEN];
    logic              wden_q  [CHAIN_LEN], wden_d  [CHAIN_LEN];
    ccf_mode_t         mode_q, mode_d;
    logic [IW-1:0]     rd_idx_q, rd_idx_d, res_dev_q, res_dev_d;
    logic [4:0]        res_ch_q, res_ch_d;
    logic              conv_q, conv_d, crcerr_q, crcerr_d;
    logic              rise, fall, cs_fall, cs_rise, hit, adc_hit;
    logic [4:0]        f_addr;
    logic              f_rw, is_wr;
    logic [5:0]        f_reg;
    logic [7:0]        f_dat, rv;
    logic [19:0]       head;
    logic [31:0]       resp;
    logic [4:0]        res_last;
    assign lnk.miso     = sh_out_q[31];
    assign mode_o       = mode_q;
    assign conv_start_o = conv_q;
    assign crc_err_o    = crcerr_q;
    assign wd_enabled_o = wden_q[0];
    assign master_id_o  = id_q[0];
    // answer word, fixed at chip-select fall from the state then
    always_comb begin
        rv   = 8'h00;
        head = '0;
        if (mode_q == CCF_MODE_CMD && rd_idx_q < LAST_DEV) begin
            case (rdptr_q[rd_idx_q][5:0])
                CCF_REG_DEVID: rv = {1'b0, id_q[rd_idx_q], lock_q[rd_idx_q], incr_q[rd_idx_q]};
                CCF_REG_WDT:   rv = wdt_q[rd_idx_q];
                CCF_REG_WDKEY: rv = wdkey_q[rd_idx_q];
                CCF_REG_ADC:   rv = adc_q[rd_idx_q];
                CCF_REG_PAGE:  rv = page_q[rd_idx_q];
                CCF_REG_RDPTR: rv = rdptr_q[rd_idx_q];
                default:       rv = 8'h00;
            endcase
            head = {id_q[rd_idx_q], 1'b0, rdptr_q[rd_idx_q][5:0], rv}; // RQ8 RQ17
        end else if (mode_q != CCF_MODE_CMD && res_dev_q < LAST_DEV) begin
            // no converter here: result value is a marker of device and channel
            head = {id_q[res_dev_q], mode_q == CCF_MODE_SEC, 1'b0, res_ch_q,
                    3'(res_dev_q), res_ch_q}; // RQ12 RQ14 RQ17
        end
        resp = {head, ccf_crc12(head, CRC_POLY)}; // RQ19
    end
    always_comb begin
        sclk_prev_d = lnk.sclk;
        cs_prev_d   = lnk.cs_n;
        sh_in_d     = sh_in_q;
        sh_out_d    = sh_out_q;
        bit_cnt_d   = bit_cnt_q;
        id_d        = id_q;
        lock_d      = lock_q;
        incr_d      = incr_q;
        page_d      = page_q;
        rdptr_d     = rdptr_q;
        wdt_d       = wdt_q;
        wdkey_d     = wdkey_q;
        adc_d       = adc_q;
        wdseq_d     = wdseq_q;
        wden_d      = wden_q;
        mode_d      = mode_q;
        rd_idx_d    = rd_idx_q;
        res_dev_d   = res_dev_q;
        res_ch_d    = res_ch_q;
        conv_d      = 1'b0;
        crcerr_d    = 1'b0;
        hit         = 1'b0;
        adc_hit     = 1'b0;
        rise        = lnk.sclk & ~sclk_prev_q;
        fall        = ~lnk.sclk & sclk_prev_q;
        cs_fall     = cs_prev_q & ~lnk.cs_n;
        cs_rise     = ~cs_prev_q & lnk.cs_n;
        f_addr      = sh_in_q[31:27];
        f_rw        = sh_in_q[26];
        f_reg       = sh_in_q[25:20];
        f_dat       = sh_in_q[19:12];
        is_wr       = f_rw | (f_reg == CCF_REG_RDPTR);
        res_last    = (mode_q == CCF_MODE_SEC) ? CCF_N_SECOND - 5'd1 : CCF_N_PRIMARY - 5'd1;
        if (cs_fall) begin
            sh_out_d  = resp;
            bit_cnt_d = 6'd0;
        end else if (!lnk.cs_n) begin
            if (rise) begin
                sh_in_d = {sh_in_q[30:0], lnk.mosi};
                bit_cnt_d = (bit_cnt_q == 6'h3f) ? bit_cnt_q : bit_cnt_q + 6'd1;
            end
            if (fall) begin
                sh_out_d = {sh_out_q[30:0], 1'b0};
            end
        end
        // a frame of any other length is dropped whole
        if (cs_rise && bit_cnt_q == 6'(CCF_FRAME_BITS)) begin // RQ1
            if (CRC_CHECK && ccf_crc12(sh_in_q[31:12], CRC_POLY) != sh_in_q[11:0]) begin
                crcerr_d = 1'b1; // RQ19
            end else begin
                // every good frame moves result readback on, only a null one register readback; a command in it may then redirect
                if (mode_q == CCF_MODE_CMD) begin
                    if (sh_in_q == '0 && rd_idx_q < LAST_DEV) begin
                        rd_idx_d = rd_idx_q + IW'(1); // RQ8
                    end
                end else if (res_dev_q < LAST_DEV) begin
                    if (res_ch_q == res_last) begin
                        res_ch_d  = 5'd0;
                        res_dev_d = res_dev_q + IW'(1); // RQ12
                    end else begin
                        res_ch_d = res_ch_q + 5'd1;
                    end
                end
                for (int k = 0; k < CHAIN_LEN; k++) begin
                    hit = (f_addr == CCF_BCAST_ADDR) || (f_addr == id_q[k]); // RQ2
                    if (is_wr && hit) begin
                        if (f_reg == CCF_REG_PAGE) begin
                            page_d[k] = f_dat; // RQ3
                        end else if (f_reg == CCF_REG_RDPTR) begin
                            rdptr_d[k] = f_dat; // RQ18
                            rd_idx_d   = '0; // RQ7
                        end else if (page_q[k] == CCF_PAGE0 && f_reg == CCF_REG_ADC) begin
                            adc_d[k] = f_dat;
                            adc_hit  = 1'b1;
                        end else if (page_q[k] == CCF_PAGE1 && f_reg == CCF_REG_DEVID) begin
                            lock_d[k] = f_dat[CCF_LOCK_BIT]; // RQ4
                            incr_d[k] = f_dat[CCF_INCR_BIT];
                            if (!lock_q[k]) begin
                                if (f_dat[CCF_INCR_BIT] && f_addr == CCF_BCAST_ADDR) begin
                                    id_d[k] = f_dat[CCF_ID_LSB+:5] + 5'(k); // RQ6
                                end else begin
                                    id_d[k] = f_dat[CCF_ID_LSB+:5];
                                end
                            end
                        end else if (page_q[k] == CCF_PAGE1 && f_reg == CCF_REG_WDT) begin
                            wdt_d[k] = f_dat;
                            if (f_dat != 8'h00) begin
                                wdseq_d[k] = CCF_WD_IDLE;
                            end else if (wdseq_q[k] == CCF_WD_KEYED) begin
                                wden_d[k]  = 1'b0; // RQ16
                                wdseq_d[k] = CCF_WD_IDLE;
                            end else begin
                                wdseq_d[k] = CCF_WD_ARMED;
                            end
                        end else if (page_q[k] == CCF_PAGE1 && f_reg == CCF_REG_WDKEY) begin
                            wdkey_d[k] = f_dat;
                            if (f_dat == CCF_WD_KEY && wdseq_q[k] == CCF_WD_ARMED) begin
                                wdseq_d[k] = CCF_WD_KEYED; // RQ16
                            end else begin
                                wdseq_d[k] = CCF_WD_IDLE;
                            end
                        end
                    end
                end
                if (adc_hit) begin
                    if (f_dat[CCF_ADC_EXIT]) begin
                        mode_d = CCF_MODE_CMD; // RQ15
                    end else if (f_dat[CCF_ADC_SECOND]) begin
                        mode_d    = CCF_MODE_SEC; // RQ14
                        res_dev_d = '0;
                        res_ch_d  = 5'd0;
                    end else if (f_dat[CCF_ADC_START]) begin
                        conv_d    = 1'b1; // RQ9
                        mode_d    = CCF_MODE_PRI; // RQ10
                        res_dev_d = '0;
                        res_ch_d  = 5'd0;
                    end
                end
            end
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sclk_prev_q <= 1'b0;
            cs_prev_q   <= 1'b1;
            sh_in_q     <= '0;
            sh_out_q    <= '0;
            bit_cnt_q   <= 6'd0;
            mode_q      <= CCF_MODE_CMD;
            rd_idx_q    <= '0;
            res_dev_q   <= '0;
            res_ch_q    <= 5'd0;
            conv_q      <= 1'b0;
            crcerr_q    <= 1'b0;
            for (int k = 0; k < CHAIN_LEN; k++) begin
                id_q[k]    <= CCF_RST_ID; // RQ5
                lock_q[k]  <= 1'b0;
                incr_q[k]  <= 1'b0;
                page_q[k]  <= CCF_PAGE0;
                rdptr_q[k] <= CCF_RST_RDPTR; // RQ18
                wdt_q[k]   <= CCF_RST_WDT;
                wdkey_q[k] <= CCF_RST_ZERO;
                adc_q[k]   <= CCF_RST_ZERO;
                wdseq_q[k] <= CCF_WD_IDLE;
                wden_q[k]  <= 1'b1;
            end
        end else begin
            sclk_prev_q <= sclk_prev_d;
            cs_prev_q   <= cs_prev_d;
            sh_in_q     <= sh_in_d;
            sh_out_q    <= sh_out_d;
            bit_cnt_q   <= bit_cnt_d;
            mode_q      <= mode_d;
            rd_idx_q    <= rd_idx_d;
            res_dev_q   <= res_dev_d;
            res_ch_q    <= res_ch_d;
            conv_q      <= conv_d;
            crcerr_q    <= crcerr_d;
            id_q        <= id_d;
            lock_q      <= lock_d;
            incr_q      <= incr_d;
            page_q      <= page_d;
            rdptr_q     <= rdptr_d;
            wdt_q       <= wdt_d;
            wdkey_q     <= wdkey_d;
            adc_q       <= adc_d;
            wdseq_q     <= wdseq_d;
            wden_q      <= wden_d;
        end
    end
endmodule : ccf_device_end

//--- verilog/ccf_host_end.sv
// host end: turns a 20-bit command head into one crc-protected frame
// assumes software on a plain register port; makes sclk by division
`timescale 1ns/1ps
module ccf_host_end
    import ccf_pkg::*;
#(
    parameter int          SCLK_HALF = CCF_SCLK_HALF,
    parameter logic [11:0] CRC_POLY  = CCF_CRC_POLY
) (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    // register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        we_i,
    input  wire logic        re_i,
    output logic      [31:0] rdata_o,
    // link
    ccf_link_if.host         lnk
);
    typedef enum logic [2:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_TAIL, HS_GAP} ccf_hstate_t;
    localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);

    ccf_hstate_t st_q, st_d;
    logic [7:0]  div_q, div_d;
    logic [4:0]  bit_q, bit_d;
    logic [31:0] tx_q, tx_d, rx_q, rx_d, resp_q, resp_d, rdata_q, rdata_d;
    logic        sclk_q, sclk_d, cs_n_q, cs_n_d, mosi_q, mosi_d, crc_ok_q, crc_ok_d;
    logic [15:0] frames_q, frames_d;
    logic [31:0] word;

    assign lnk.sclk = sclk_q;
    assign lnk.cs_n = cs_n_q;
    assign lnk.mosi = mosi_q;
    assign rdata_o  = rdata_q;

    always_comb begin
        st_d     = st_q;
        div_d    = div_q;
        bit_d    = bit_q;
        tx_d     = tx_q;
        rx_d     = rx_q;
        resp_d   = resp_q;
        sclk_d   = sclk_q;
        cs_n_d   = cs_n_q;
        mosi_d   = mosi_q;
        crc_ok_d = crc_ok_q;
        frames_d = frames_q;
        rdata_d  = 32'h0;
        word     = {wdata_i[19:0], ccf_crc12(wdata_i[19:0], CRC_POLY)}; // RQ19
        if (re_i) begin
            case (addr_i)
                CCF_HOST_RESP: rdata_d = resp_q;
                CCF_HOST_STAT: rdata_d = {frames_q, 14'h0, crc_ok_q, st_q != HS_IDLE};
                default:       rdata_d = 32'h0;
            endcase
        end
        case (st_q)
            HS_IDLE: begin
                // a command written while busy is dropped; software polls busy
                if (we_i && addr_i == CCF_HOST_CMD) begin
                    tx_d   = word; // RQ1
                    mosi_d = word[31];
                    cs_n_d = 1'b0;
                    div_d  = 8'h0;
                    bit_d  = 5'd0;
                    st_d   = HS_LOW;
                end
            end
            HS_LOW: begin
                div_d = div_q + 8'h1;
                if (div_q == HALF_LAST) begin
                    sclk_d = 1'b1;
                    div_d  = 8'h0;
                    rx_d   = {rx_q[30:0], lnk.miso}; // RQ8
                    st_d   = HS_HIGH;
                end
            end
            HS_HIGH: begin
                div_d = div_q + 8'h1;
                if (div_q == HALF_LAST) begin
                    sclk_d = 1'b0;
                    div_d  = 8'h0;
                    if (bit_q == 5'd31) begin
                        st_d = HS_TAIL; // RQ1
                    end else begin
                        bit_d  = bit_q + 5'd1;
                        tx_d   = {tx_q[30:0], 1'b0};
                        mosi_d = tx_q[30];
                        st_d   = HS_LOW;
                    end
                end
            end
            HS_TAIL: begin
                div_d = div_q + 8'h1;
                if (div_q == HALF_LAST) begin
                    cs_n_d   = 1'b1;
                    mosi_d   = 1'b0;
                    div_d    = 8'h0;
                    resp_d   = rx_q;
                    crc_ok_d = ccf_crc12(rx_q[31:12], CRC_POLY) == rx_q[11:0]; // RQ19
                    frames_d = frames_q + 16'h1;
                    st_d     = HS_GAP;
                end
            end
            HS_GAP: begin
                div_d = div_q + 8'h1;
                if (div_q == HALF_LAST) begin
                    div_d = 8'h0;
                    st_d  = HS_IDLE;
                end
            end
            default: st_d = HS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st_q     <= HS_IDLE;
            div_q    <= 8'h0;
            bit_q    <= 5'd0;
            tx_q     <= 32'h0;
            rx_q     <= 32'h0;
            resp_q   <= 32'h0;
            rdata_q  <= 32'h0;
            sclk_q   <= 1'b0;
            cs_n_q   <= 1'b1;
            mosi_q   <= 1'b0;
            crc_ok_q <= 1'b0;
            frames_q <= 16'h0;
        end else begin
            st_q     <= st_d;
            div_q    <= div_d;
            bit_q    <= bit_d;
            tx_q     <= tx_d;
            rx_q     <= rx_d;
            resp_q   <= resp_d;
            rdata_q  <= rdata_d;
            sclk_q   <= sclk_d;
            cs_n_q   <= cs_n_d;
            mosi_q   <= mosi_d;
            crc_ok_q <= crc_ok_d;
            frames_q <= frames_d;
        end
    end
endmodule : ccf_host_end

//--- verification/ccf_link_checker.sv
// wire checker for the chained command frame link
// assumes host sclk half period of 4 system clocks
`timescale 1ns/1ps
module ccf_link_checker (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso
);
    logic [5:0] rise_cnt_q;
    logic [5:0] rise_cnt_d;
    logic       sclk_q;
    logic       cs_q;
    // counts rises per frame, cleared as a frame opens
    always_comb begin
        rise_cnt_d = rise_cnt_q;
        if (!cs_n && cs_q) begin
            rise_cnt_d = 6'h00;
        end else if (sclk && !sclk_q) begin
            rise_cnt_d = rise_cnt_q + 6'h01;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rise_cnt_q <= 6'h00;
            sclk_q     <= 1'b0;
            cs_q       <= 1'b1;
        end else begin
            rise_cnt_q <= rise_cnt_d;
            sclk_q     <= sclk;
            cs_q       <= cs_n;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    chk_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("sclk high outside a frame");
    chk_rise_in_frame: assert property ($rose(sclk) |-> !cs_n)
        else $error("sclk rise without select");
    chk_frame_len: assert property ($rose(cs_n) |-> rise_cnt_q == 6'd32)
        else $error("frame not 32 clocks");
    chk_mosi_steady: assert property ($rose(sclk) |-> $stable(mosi))
        else $error("mosi moved at sclk rise");
    chk_miso_steady: assert property ($rose(sclk) |-> $stable(miso))
        else $error("miso moved at sclk rise");
    chk_sclk_high_time: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
        else $error("sclk high time wrong");
    chk_first_rise: assert property ($fell(cs_n) |-> !sclk[*4] ##1 sclk)
        else $error("first sclk rise late or early");
    chk_frame_close: assert property ((rise_cnt_q == 6'd32 && $fell(sclk))
        |-> !cs_n[*4] ##1 cs_n)
        else $error("select not released after last clock");
    cov_frame: cover property ($rose(cs_n));
    cov_full: cover property (rise_cnt_q == 6'd32);
    cov_miso: cover property (!cs_n && miso);
endmodule : ccf_link_checker

//--- verification/tb.sv
// testbench: host end drives the device end through the link
// assumes a chain of three devices and matching crc on both ends
`timescale 1ns/1ps
module tb;
    import ccf_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        we = 1'b0;
    logic        re = 1'b0;
    logic [31:0] rdata;
    logic [31:0] r;
    ccf_mode_t   mode;
    logic        conv_start;
    logic        crc_err;
    logic        wd_en;
    logic [4:0]  mid;
    logic [19:0] e;
    int          n_mismatch = 0;
    int          compares = 0;
    int          cycles = 0;
    int          starts = 0;
    int          crc_errs = 0;
    always #5 sys_clk = ~sys_clk;
    ccf_link_if lnk_if ();
    ccf_host_end ccf_host_end_inst (.sys_clk_i(sys_clk), .reset_i(rst), .addr_i(addr),
        .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata), .lnk(lnk_if));
    ccf_device_end ccf_device_end_inst (.sys_clk_i(sys_clk), .reset_i(rst), .lnk(lnk_if),
        .mode_o(mode), .conv_start_o(conv_start), .crc_err_o(crc_err),
        .wd_enabled_o(wd_en), .master_id_o(mid));
    ccf_link_checker ccf_link_checker_inst (.sys_clk_i(sys_clk), .reset_i(rst),
        .sclk(lnk_if.sclk), .cs_n(lnk_if.cs_n), .mosi(lnk_if.mosi), .miso(lnk_if.miso));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run;
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge sys_clk);
        we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        re <= 1'b1;
        @(posedge sys_clk);
        re <= 1'b0;
        #1 d = rdata;
    endtask : rd
    // one command frame, then its response word lands in r
    task automatic frame(input logic [4:0] da, input logic rw, input logic [5:0] ra,
                         input logic [7:0] dt);
        logic [31:0] s;
        wr(CCF_HOST_CMD, {12'h000, da, rw, ra, dt});
        s = 32'h1;
        for (int i = 0; i < 400 && s[0] !== 1'b0; i++) rd(CCF_HOST_STAT, s);
        chk({31'h0, s[1]}, 32'h1);
        rd(CCF_HOST_RESP, r);
    endtask : frame
    // a conversion pulse is sampled off the active edge
    always @(negedge sys_clk) begin
        cycles++;
        if (conv_start === 1'b1) starts++;
        if (crc_err === 1'b1) crc_errs++;
        if (cycles == 60000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        #1 chk({27'h0, mid}, 32'h0);
        chk({31'h0, wd_en}, 32'h1);
        rd(4'hc, r);
        chk(r, 32'h0);
        frame(CCF_BCAST_ADDR, 1'b1, CCF_REG_PAGE, CCF_PAGE1);
        frame(CCF_BCAST_ADDR, 1'b1, CCF_REG_DEVID, 8'h09);
        chk({27'h0, mid}, 32'h2);
        frame(CCF_BCAST_ADDR, 1'b0, CCF_REG_RDPTR, 8'h0a);
        for (int k = 0; k < 4; k++) begin
            frame(5'h00, 1'b0, 6'h00, 8'h00);
            e = (k < 3) ? {5'd2 + k[4:0], 1'b0, 6'h0a, 1'b0, 5'd2 + k[4:0], 2'b01} : 20'h0;
            chk({12'h0, r[31:12]}, {12'h0, e});
        end
        frame(CCF_BCAST_ADDR, 1'b1, CCF_REG_WDT, 8'h00);
        frame(CCF_BCAST_ADDR, 1'b1, CCF_REG_WDKEY, 8'h00);
        frame(CCF_BCAST_ADDR, 1'b1, CCF_REG_WDT, 8'h00);
        chk({31'h0, wd_en}, 32'h1);
        frame(CCF_BCAST_ADDR, 1'b1, CCF_REG_WDKEY, CCF_WD_KEY);
        frame(CCF_BCAST_ADDR, 1'b1, CCF_REG_WDT, 8'h00);
        chk({31'h0, wd_en}, 32'h0);
        frame(CCF_BCAST_ADDR, 1'b1, CCF_REG_PAGE, CCF_PAGE0);
        frame(5'h07, 1'b1, CCF_REG_ADC, 8'h01);
        chk({30'h0, mode}, {30'h0, CCF_MODE_CMD});
        frame(CCF_BCAST_ADDR, 1'b1, CCF_REG_ADC, 8'h01);
        chk({30'h0, mode}, {30'h0, CCF_MODE_PRI});
        repeat (200) @(posedge sys_clk);
        for (int f = 0; f < 84; f++) begin
            automatic int sc = (f >= 54);
            automatic int ix = sc ? f - 54 : f;
            automatic int dv = sc ? ix / 10 : ix / 18;
            automatic int ch = sc ? ix % 10 : ix % 18;
            if (f == 53) frame(CCF_BCAST_ADDR, 1'b1, CCF_REG_ADC, 8'h02);
            else if (f == 83) frame(CCF_BCAST_ADDR, 1'b1, CCF_REG_ADC, 8'h04);
            else frame(5'h00, 1'b0, 6'h00, 8'h00);
            e = {5'd2 + dv[4:0], sc[0], 1'b0, ch[4:0], dv[2:0], ch[4:0]};
            chk({12'h0, r[31:12]}, {12'h0, e});
            if (f == 53) chk({30'h0, mode}, {30'h0, CCF_MODE_SEC});
        end
        chk({30'h0, mode}, {30'h0, CCF_MODE_CMD});
        chk(starts, 32'h1);
        chk(crc_errs, 32'h0);
        rd(CCF_HOST_STAT, r);
        chk(r, {16'd99, 14'h0, 2'b10});
        complete_run();
    end
endmodule : tb
